// >>> src/adcsr_readout.sv
// Purpose: Frame and bit sequencing of a 12-bit differential SAR converter
// Assumes: Serial clock and frame select are synchronous to i_clk and
//          slow enough that each level lasts at least one i_clk cycle
// Notes:   Samples arrive digitised through a 16-word buffer
`timescale 1ns/1ps
`include "adcsr_map.svh"

module adcsr_readout
  import adcsr_pkg::*;
#(
  parameter int IN_W = `ADCSR_IN_W,
  parameter int FIFO_DEPTH = `ADCSR_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_samp_valid,
  output logic o_samp_ready,
  input wire logic [IN_W-1:0] i_samp_data,
  output logic o_acquire_phase,
  output logic o_convert_phase,
  output logic o_idle,
  output logic [`ADCSR_RES_W-1:0] o_result
);

  // ========================================================
  // Clamp of the digitised input to the 12-bit code range
  function automatic logic [`ADCSR_RES_W-1:0] clamp_code(
    input logic [IN_W-1:0] raw
  );
    logic signed [IN_W-1:0] s;
    logic signed [IN_W-1:0] pos_lim;
    logic signed [IN_W-1:0] neg_lim;
    s = signed'(raw);
    pos_lim = IN_W'(signed'(`ADCSR_POS_FS));
    neg_lim = -pos_lim - IN_W'(1);
    if (s >= pos_lim) begin
      clamp_code = `ADCSR_POS_FS;
    end else if (s <= neg_lim) begin
      clamp_code = `ADCSR_NEG_FS;
    end else begin
      clamp_code = s[`ADCSR_RES_W-1:0];
    end
  endfunction

  // ========================================================
  // Sample buffer
  logic fifo_valid;
  logic fifo_pop;
  logic [IN_W-1:0] fifo_data;

  // Buffer drains only during frames, so it fills while idle
  adcsr_fifo #(
    .W(IN_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_valid(i_samp_valid),
    .o_wr_ready(o_samp_ready),
    .i_wr_data(i_samp_data),
    .o_rd_valid(fifo_valid),
    .i_rd_ready(fifo_pop),
    .o_rd_data(fifo_data)
  );

  // ========================================================
  // Pin history for edge detection
  logic sclk_ff;
  logic cs_n_ff;
  logic nxt_sclk;
  logic nxt_cs_n;
  logic sclk_fall;
  logic cs_fall;

  always_comb begin
    nxt_sclk = i_sclk;
    nxt_cs_n = i_cs_n;
    sclk_fall = sclk_ff && !i_sclk;
    cs_fall = cs_n_ff && !i_cs_n;
  end

  // Pins idle high so a frame open at reset release is not missed
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
    end else begin
      sclk_ff <= nxt_sclk;
      cs_n_ff <= nxt_cs_n;
    end
  end

  // ========================================================
  // Sequencer
  adcsr_phase_e phase_ff;
  adcsr_phase_e nxt_phase;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [4:0] edge_no;
  logic [4:0] bit_sel;
  logic dout_ff;
  logic nxt_dout;
  logic [`ADCSR_RES_W-1:0] code_ff;
  logic [`ADCSR_RES_W-1:0] nxt_code;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_dout = dout_ff;
    nxt_code = code_ff;
    fifo_pop = 1'b0;
    // Edge sixteen wraps straight to the next conversion
    if (cnt_ff == `ADCSR_EDGES_PER_CONV) begin
      edge_no = `ADCSR_CNT_FIRST;
    end else begin
      edge_no = cnt_ff + `ADCSR_CNT_FIRST;
    end
    bit_sel = `ADCSR_EDGES_PER_CONV - edge_no;
    if (i_cs_n) begin
      nxt_phase = PH_IDLE;
      nxt_cnt = `ADCSR_CNT_RESET;
      nxt_dout = 1'b0;
    end else if (cs_fall) begin
      nxt_dout = 1'b0;
      if (i_sclk) begin
        nxt_phase = PH_ARMED;
        nxt_cnt = `ADCSR_CNT_RESET;
      end else begin
        // Covers both clock already low and clock falling now
        nxt_phase = PH_ACQUIRE;
        nxt_cnt = `ADCSR_CNT_FIRST;
      end
    end else if (sclk_fall) begin
      nxt_cnt = edge_no;
      if (edge_no <= `ADCSR_ACQ_EDGES) begin
        nxt_phase = PH_ACQUIRE;
      end else begin
        nxt_phase = PH_CONVERT;
      end
      if (edge_no == `ADCSR_LAST_ZERO_EDGE) begin
        // Hold point; empty buffer keeps the previous sample
        fifo_pop = fifo_valid;
        if (fifo_valid) begin
          nxt_code = clamp_code(fifo_data);
        end
      end
      if (edge_no <= `ADCSR_LAST_ZERO_EDGE) begin
        nxt_dout = 1'b0;
      end else begin
        nxt_dout = code_ff[bit_sel[3:0]];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_ff <= PH_IDLE;
      cnt_ff <= `ADCSR_CNT_RESET;
      dout_ff <= 1'b0;
      code_ff <= `ADCSR_CODE_RESET;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      dout_ff <= nxt_dout;
      code_ff <= nxt_code;
    end
  end

  // ========================================================
  // Outputs
  always_comb begin
    // Bits change on falling edges so the host can take them on rising
    o_sdo = dout_ff;
    o_sdo_oe = !i_cs_n;
    o_acquire_phase = (phase_ff == PH_ACQUIRE);
    o_convert_phase = (phase_ff == PH_CONVERT);
    o_idle = (phase_ff == PH_IDLE);
    o_result = code_ff;
  end

  // ========================================================
  // Checks
  sequence s_conv_edge(int n);
    !i_cs_n && sclk_fall && (edge_no == 5'(n));
  endsequence

  sequence s_open_low;
    !i_cs_n && cs_fall && !i_sclk;
  endsequence

  a_cnt_range: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    cnt_ff <= `ADCSR_EDGES_PER_CONV
  ) else $error("edge counter out of range");

  a_wrap_sixteen: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (cnt_ff == 5'h10) && !i_cs_n && sclk_fall && !cs_fall
    |=> (cnt_ff == 5'h01) && o_acquire_phase
  ) else $error("no return to acquisition after edge sixteen");

  a_convert_entry: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_conv_edge(4) && !cs_fall |=> o_convert_phase && (cnt_ff == 5'h04)
  ) else $error("conversion not entered at edge four");

  a_lead_zeros: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (cnt_ff >= 5'h01) && (cnt_ff <= 5'h04) && !i_cs_n |-> !o_sdo
  ) else $error("leading bit not zero");

  a_result_bit: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_conv_edge(5) && !cs_fall |=> o_sdo == $past(code_ff[11])
  ) else $error("first result bit is not the MSB");

  a_lsb_last: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_conv_edge(16) && !cs_fall |=> o_sdo == $past(code_ff[0])
  ) else $error("last result bit is not the LSB");

  a_open_low: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    s_open_low |=> o_acquire_phase && (cnt_ff == 5'h01) && o_sdo_oe
  ) else $error("frame open with clock low not counted as edge one");

  a_open_high: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    cs_fall && i_sclk && !i_cs_n
    |=> (phase_ff == PH_ARMED) && (cnt_ff == 5'h00)
  ) else $error("frame open with clock high did not wait");

  a_abort_float: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_cs_n |-> !o_sdo_oe ##1 (o_idle && (cnt_ff == 5'h00) && !o_sdo)
  ) else $error("closed frame did not abort and float");

  a_hold_sample: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $changed(code_ff) |-> $past(fifo_pop) && o_convert_phase
  ) else $error("sample changed outside the hold point");

  a_code_clamp: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    fifo_pop && (signed'(fifo_data) >= signed'(IN_W'(12'h7FF)))
    |=> code_ff == 12'h7FF
  ) else $error("positive overrange not clamped");

endmodule

// >>> src/adcsr_map.svh
// Purpose: Constants of the serial readout of the 12-bit SAR converter
// Assumes: Included by bare name; definitions only
// Notes:   Edge numbers count serial clock falling edges in one conversion
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH

// ==========================================================
// Conversion framing
`define ADCSR_EDGES_PER_CONV 5'h10
`define ADCSR_ACQ_EDGES 5'h03
`define ADCSR_LAST_ZERO_EDGE 5'h04
`define ADCSR_FIRST_RES_EDGE 5'h05
`define ADCSR_CNT_RESET 5'h00
`define ADCSR_CNT_FIRST 5'h01

// ==========================================================
// Result coding
`define ADCSR_RES_W 12
`define ADCSR_POS_FS 12'h7FF
`define ADCSR_NEG_FS 12'h800
`define ADCSR_CODE_RESET 12'h000

// ==========================================================
// Sample buffer
`define ADCSR_FIFO_DEPTH 16
`define ADCSR_IN_W 14

`endif

// >>> src/adcsr_pkg.sv
// Purpose: Types of the serial readout of the 12-bit SAR converter
// Assumes: Nothing beyond the map header
// Notes:   Phase order follows one conversion from frame open
package adcsr_pkg;

  // ========================================================
  // Conversion phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ARMED,
    PH_ACQUIRE,
    PH_CONVERT
  } adcsr_phase_e;

endpackage

// >>> src/adcsr_fifo.sv
// Purpose: Sample buffer between the analog front end and the readout
// Assumes: One clock, asynchronous active-low reset
// Notes:   Full and empty are exact; a pointer carries one extra wrap bit
`timescale 1ns/1ps

module adcsr_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic [AW:0] nxt_wr_ptr;
  logic [AW:0] nxt_rd_ptr;
  logic do_wr;
  logic do_rd;

  // ========================================================
  // Status and pointers
  always_comb begin
    o_rd_valid = (wr_ptr_ff != rd_ptr_ff);
    o_wr_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                   (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    do_wr = i_wr_valid && o_wr_ready;
    do_rd = i_rd_ready && o_rd_valid;
    nxt_wr_ptr = do_wr ? wr_ptr_ff + {{AW{1'b0}}, 1'b1} : wr_ptr_ff;
    nxt_rd_ptr = do_rd ? rd_ptr_ff + {{AW{1'b0}}, 1'b1} : rd_ptr_ff;
    o_rd_data = mem[rd_ptr_ff[AW-1:0]];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // Storage has no reset; empty flag hides stale words
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff[AW-1:0]] <= i_wr_data;
    end
  end

endmodule

// >>> dv/adcsr_host_model.sv
// Purpose: Host side of the serial link; drives clock and select
// Assumes: Levels change only at falling i_clk
// Notes:   Serial clock stands still between frames
`timescale 1ns/1ps

module adcsr_host_model #(
  parameter int HALF = 4
) (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  input wire logic i_sdo
);
  logic [63:0] bits;

  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    bits = '0;
  end

  task automatic hold();
    repeat (HALF) @(negedge i_clk);
  endtask

  // ==========================================================
  // Frame: mode 0 opens with clock low, 1 high, 2 both falling
  task automatic frame(input int mode, input int n);
    @(negedge i_clk);
    bits = '0;
    if (mode == 0) begin
      // Clock edge with select high must be ignored
      o_sclk = 1'b0;
      hold();
    end
    o_cs_n = 1'b0;
    if (mode == 2) begin
      o_sclk = 1'b0;
    end
    hold();
    if (mode == 1) begin
      o_sclk = 1'b0;
      hold();
    end
    for (int i = 0; i < n; i++) begin
      bits = {bits[62:0], i_sdo};
      o_sclk = 1'b1;
      hold();
      if (i < n - 1) begin
        o_sclk = 1'b0;
        hold();
      end
    end
    o_cs_n = 1'b1;
    hold();
  endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the serial readout
// Assumes: Host model drives the link; bench feeds samples
// Notes:   Codes follow the clamp and framing rules
`timescale 1ns/1ps
`include "adcsr_map.svh"

module tb_top;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic samp_valid = 1'b0;
  logic [13:0] samp_data = '0;
  logic sclk, cs_n, sdo, sdo_oe, samp_ready, acq, conv, idle;
  logic [11:0] result;
  wire sdo_line = sdo_oe ? sdo : 1'bz;
  int bad_count = 0;
  int tests_run = 0;
  // Sticky phase flags, cleared by a scenario before its frame
  logic saw_acq = 1'b0;
  logic saw_conv = 1'b0;

  always @(posedge i_clk) begin
    if (acq) begin
      saw_acq <= 1'b1;
    end
    if (conv) begin
      saw_conv <= 1'b1;
    end
  end

  always #12.5 i_clk = ~i_clk;

  adcsr_readout u_adcsr_readout (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk),
    .i_cs_n(cs_n), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_samp_valid(samp_valid), .o_samp_ready(samp_ready),
    .i_samp_data(samp_data), .o_acquire_phase(acq),
    .o_convert_phase(conv), .o_idle(idle), .o_result(result)
  );

  adcsr_host_model u_adcsr_host_model (
    .i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n), .i_sdo(sdo_line)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [63:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic push(input logic [13:0] d);
    @(negedge i_clk);
    samp_valid = 1'b1;
    samp_data = d;
    @(negedge i_clk);
    samp_valid = 1'b0;
  endtask

  task automatic run(input int mode, n, input logic [63:0] e);
    u_adcsr_host_model.frame(mode, n);
    chk("sdo bits", e, u_adcsr_host_model.bits);
    chk("idle", 64'h1, {63'h0, idle});
    chk("sdo float", {63'h0, 1'bz}, {63'h0, sdo_line});
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("idle", 64'h1, {63'h0, idle});
    chk("ready", 64'h1, {63'h0, samp_ready});
    chk("sdo float", {63'h0, 1'bz}, {63'h0, sdo_line});
    $display("t_reset done");
  endtask

  task automatic t_modes();
    push(14'h0123);
    run(0, 16, 64'h0123);
    chk("result", 64'h123, {52'h0, result});
    push(14'h3FFF);
    run(1, 16, 64'h0FFF);
    push(14'h0800);
    run(2, 16, 64'h07FF);
    $display("t_modes done");
  endtask

  task automatic t_cont();
    push(14'h37FF);
    push(14'h0055);
    run(0, 32, 64'h0800_0055);
    $display("t_cont done");
  endtask

  task automatic t_abort();
    push(14'h05A5);
    run(0, 8, 64'h05);
    push(14'h03C3);
    run(1, 16, 64'h03C3);
    $display("t_abort done");
  endtask

  task automatic t_phase();
    @(negedge i_clk);
    saw_acq = 1'b0;
    saw_conv = 1'b0;
    u_adcsr_host_model.frame(1, 3);
    chk("acquire seen", 64'h1, {63'h0, saw_acq});
    chk("convert seen", 64'h0, {63'h0, saw_conv});
    chk("idle", 64'h1, {63'h0, idle});
    @(negedge i_clk);
    saw_acq = 1'b0;
    saw_conv = 1'b0;
    u_adcsr_host_model.frame(0, 5);
    chk("acquire seen", 64'h1, {63'h0, saw_acq});
    chk("convert seen", 64'h1, {63'h0, saw_conv});
    chk("phase off", 64'h0, {62'h0, acq, conv});
    $display("t_phase done");
  endtask

  task automatic t_full();
    for (int i = 0; i < `ADCSR_FIFO_DEPTH; i++) begin
      push(14'(i * 65));
    end
    chk("ready", 64'h0, {63'h0, samp_ready});
    // Refused word must never surface
    push(14'h0111);
    for (int i = 0; i < `ADCSR_FIFO_DEPTH; i++) begin
      run(0, 16, 64'(i * 65));
    end
    // Empty buffer keeps the last code
    run(1, 16, 64'(15 * 65));
    $display("t_full done");
  endtask

  initial begin
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_modes();
    t_cont();
    t_abort();
    t_phase();
    t_full();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    print_verdict();
  end
endmodule
